// ### verilog/measure_start_n_port_params.svh
/*
 Timing counts, field layouts and register offsets for the trigger and
 judgment port. Assumes a 25 MHz system clock.
*/
`ifndef MEASURE_START_N_PORT_PARAMS_SVH
`define MEASURE_START_N_PORT_PARAMS_SVH

`define CLK_HZ            25000000
`define MEASURE_START_N_MIN_US       100
// Clock scaled to kHz first so the product stays inside a 32-bit integer
`define MEASURE_START_N_MIN_CYC      ((`MEASURE_START_N_MIN_US * (`CLK_HZ / 1000) + 999) / 1000)
`define DELAY_W           20
`define JUDGE_W           8
`define REG_ADDR_W        4

`define OFF_CTRL          4'h0
`define OFF_DELAY         4'h1
`define OFF_STATUS        4'h2
`define OFF_RESULT        4'h3

`define CTRL_RESET_BIT    0
`define CTRL_TRIGEN_BIT   1
`define CTRL_EDGE_BIT     2
`define CTRL_RESET_VAL    3'h1
`define DELAY_RESET_VAL   20'h00000

`endif

// ### verilog/measure_start_n_port_pkg.sv
/*
 Types for the trigger and judgment port.
 Assumes measure_start_n_port_params.svh supplies the numbers.
*/
package measure_start_n_port_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_MEASURE,
      ST_HOLD
   } port_state_t;
endpackage

// ### verilog/measure_start_n_sync.sv
/*
 Three-stage synchroniser with agreement check and edge select.
 Assumes an asynchronous pin input and one system clock.
*/
`timescale 1ns/100ps
module measure_start_n_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Pin and selection
   input  wire logic pin_in,
   input  wire logic edge_rise,
   // Result
   output logic      start_pulse
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;
   wire  agree = (s2_r == s3_r);
   wire  chg   = agree && (s3_r != level_r);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_r    <= 1'b1;
         s2_r    <= 1'b1;
         s3_r    <= 1'b1;
         level_r <= 1'b1;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (chg) begin
            level_r <= s3_r;
         end
      end
   end

   // Rising on the pin is trigger release; falling is the switch closing
   assign start_pulse = chg && (s3_r == edge_rise);
endmodule

// ### verilog/measure_start_n_judge_port.sv
/*
 Trigger and judgment handshake of the isolated control port.
 Assumes a measurement engine that raises meas_done with its results and
 error flags, and a register master on the plain strobe port.
*/
// Design decisions made here: the strobed register port and the placing of the registers.
// Operation
// - After judgment outputs appear, the end strobe goes low only after the programmed delay.
// - A setting chooses whether judgments clear at measurement start or hold their old value.
// - A setting accepts or ignores triggers while a measurement runs.
// - The trigger is taken on the rising or falling transition per a setting.
// - By default judgments are released at start and driven only once the measurement ends.
// - The error output goes low on any sampling, regulation, limit, contact or high-impedance fault.
// - All control outputs are low when asserted and high when inactive.
// - Hardware triggers are still taken while the communications side reads data.
// - A trigger taken with both done strobes low drives both high as measurement starts.
`timescale 1ns/100ps
`include "measure_start_n_port_params.svh"
module measure_start_n_judge_port
   import measure_start_n_port_pkg::*;
#(
   parameter int DELAY_W = `DELAY_W,
   parameter int JUDGE_W = `JUDGE_W
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // Control port pins
   input  wire logic                   measure_start_n,
   output logic                        measure_done_n,
   output logic                        analog_done_n,
   output logic [JUDGE_W-1:0]          judge_n,
   output logic                        meas_error_n,
   // Measurement engine
   output logic                        meas_start,
   input  wire logic                   analog_end,
   input  wire logic                   meas_done,
   input  wire logic [JUDGE_W-1:0]     judge_in,
   input  wire logic [4:0]             fault_in,
   // Register port
   input  wire logic [`REG_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [31:0]                 reg_rdata
);
   // Refused at elaboration: read-back packs each field into one bus word
   if (DELAY_W < 1 || DELAY_W > 31 || JUDGE_W < 1 || JUDGE_W > 32) begin
      $error("measure_start_n_judge_port: unsupported width");
   end

   port_state_t        state_r;
   port_state_t        state_nxt;
   logic [2:0]         ctrl_r;
   logic [DELAY_W-1:0] delay_r;
   logic [DELAY_W-1:0] cnt_r;
   logic [JUDGE_W-1:0] judge_r;
   logic               err_r;
   logic               done_r;
   logic               adone_r;
   logic               start_pulse;
   logic [31:0]        rdata_r;

   wire clr_at_start = ctrl_r[`CTRL_RESET_BIT];
   wire measure_start_n_in_meas = ctrl_r[`CTRL_TRIGEN_BIT];
   wire edge_rise    = ctrl_r[`CTRL_EDGE_BIT];
   wire busy         = (state_r != ST_IDLE);
   // Edges while busy are simply dropped when disabled; nothing is latched
   wire accept       = start_pulse && (!busy || measure_start_n_in_meas);
   wire delay_over   = (cnt_r == '0);
   wire any_fault    = |fault_in;

   measure_start_n_sync u_sync (
      .clk         (clk),
      .rst         (rst),
      .pin_in      (measure_start_n),
      .edge_rise   (edge_rise),
      .start_pulse (start_pulse)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:    if (accept) state_nxt = ST_MEASURE;
         ST_MEASURE: if (meas_done) state_nxt = ST_HOLD;
         ST_HOLD:    if (delay_over) state_nxt = ST_IDLE;
         default:    state_nxt = ST_IDLE;
      endcase
      if (accept) begin
         state_nxt = ST_MEASURE;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_MEASURE && meas_done) begin
            cnt_r <= delay_r;
         end else if (state_r == ST_HOLD && !delay_over) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

   // Judgment and error latches; active-high internally, inverted at the pins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         judge_r <= '0;
         err_r   <= 1'b0;
      end else if (state_r == ST_MEASURE && meas_done && !accept) begin
         judge_r <= judge_in;
         err_r   <= any_fault;
      end else if (accept && clr_at_start) begin
         judge_r <= '0;
         err_r   <= 1'b0;
      end
   end

   // Done strobes: high from start; end strobe low when the delay has run out, analog strobe low at analog_end or meas_done
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_r  <= 1'b1;
         adone_r <= 1'b1;
      end else if (accept) begin
         done_r  <= 1'b1;
         adone_r <= 1'b1;
      end else begin
         if (state_r == ST_HOLD && delay_over) begin
            done_r <= 1'b0;
         end
         if (state_r == ST_MEASURE && analog_end) begin
            adone_r <= 1'b0;
         end else if (state_r == ST_MEASURE && meas_done) begin
            adone_r <= 1'b0;
         end
      end
   end

   // Reset value leaves both done strobes released until the delay of the first measurement has run out
   logic pins_live_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pins_live_r <= 1'b0;
      end else if (state_r == ST_HOLD && delay_over) begin
         pins_live_r <= 1'b1;
      end
   end

   // Open-collector style: low sinks current, high is released
   assign measure_done_n = pins_live_r ? done_r : 1'b1;
   assign analog_done_n  = pins_live_r ? adone_r : 1'b1;
   assign judge_n        = ~judge_r;
   assign meas_error_n   = ~err_r;
   assign meas_start     = accept;

   // Register port: configuration and status, one-cycle read latency
   wire sel_ctrl   = (reg_addr == `OFF_CTRL);
   wire sel_delay  = (reg_addr == `OFF_DELAY);
   wire sel_status = (reg_addr == `OFF_STATUS);
   wire sel_result = (reg_addr == `OFF_RESULT);
   logic [31:0] rd_mux;

   assign rd_mux = sel_ctrl   ? {29'h0, ctrl_r} :
                   sel_delay  ? {{(32-DELAY_W){1'b0}}, delay_r} :
                   sel_status ? {27'h0, err_r, adone_r, done_r, state_r} :
                   sel_result ? {{(32-JUDGE_W){1'b0}}, judge_r} :
                   32'h0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r  <= `CTRL_RESET_VAL;
         delay_r <= DELAY_W'(`DELAY_RESET_VAL);
         rdata_r <= 32'h0;
      end else begin
         if (reg_wr && sel_ctrl) begin
            ctrl_r <= reg_wdata[2:0];
         end else if (reg_wr && sel_delay) begin
            delay_r <= reg_wdata[DELAY_W-1:0];
         end
         rdata_r <= reg_rd ? rd_mux : 32'h0;
      end
   end
   assign reg_rdata = rdata_r;

   a_delay_before_done: assert property (@(posedge clk) disable iff (rst)
      (state_r == ST_HOLD && !delay_over) |-> ##1 (done_r || state_r == ST_MEASURE))
      else $error("end strobe fell before delay expired");

   a_clear_on_start: assert property (@(posedge clk) disable iff (rst)
      (accept && clr_at_start && !(state_r == ST_MEASURE && meas_done)) |=> (judge_n == '1))
      else $error("judgments not cleared at start");

   a_hold_on_start: assert property (@(posedge clk) disable iff (rst)
      (accept && !clr_at_start) |=> $stable(judge_r))
      else $error("judgments changed at start in hold mode");

   a_drop_busy_measure_start_n: assert property (@(posedge clk) disable iff (rst)
      (busy && !measure_start_n_in_meas) |-> !meas_start ##1 (state_r != ST_MEASURE || $past(state_r) == ST_MEASURE))
      else $error("trigger taken during measurement while disabled");

   a_take_idle_measure_start_n: assert property (@(posedge clk) disable iff (rst)
      (start_pulse && !busy) |=> (state_r == ST_MEASURE))
      else $error("idle trigger not taken");

   a_done_high_start: assert property (@(posedge clk) disable iff (rst)
      accept |=> (done_r && adone_r))
      else $error("done strobes not raised at start");

   a_error_latch: assert property (@(posedge clk) disable iff (rst)
      (state_r == ST_MEASURE && meas_done && !accept && any_fault) |=> !meas_error_n)
      else $error("fault not reported");

   a_result_update: assert property (@(posedge clk) disable iff (rst)
      (state_r == ST_MEASURE && meas_done && !accept) |=> (judge_n == ~$past(judge_in)))
      else $error("judgment not driven at end");
endmodule

// ### tb/plc_model.sv
/*
 External controller that pulses the trigger pin.
 Assumes one clock; fire is a one-cycle request while busy is low.
*/
`timescale 1ns/100ps
module plc_model #(
   parameter int HOLD_CYC = 2500
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Request and pin
   input  wire logic fire,
   output logic      measure_start_n,
   output logic      busy
);
   int cnt_r;
   // Released pin sits at the pull-up level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r           <= 0;
         measure_start_n <= 1'b1;
      end else if (fire && cnt_r == 0) begin
         cnt_r           <= 2 * HOLD_CYC;
         measure_start_n <= 1'b0;
      end else if (cnt_r != 0) begin
         cnt_r <= cnt_r - 1;
         if (cnt_r == HOLD_CYC + 1) measure_start_n <= 1'b1;
      end
   end
   assign busy = (cnt_r != 0);
endmodule

// ### tb/measure_start_n_judge_port_tb.sv
/*
 Bench for the trigger and judgment port.
 Assumes plc_model on the pin; the bench plays the engine and the register master.
*/
`timescale 1ns/100ps
`include "measure_start_n_port_params.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module measure_start_n_judge_port_tb;
   typedef struct {logic [2:0] c; logic [19:0] d; logic [7:0] j; logic [4:0] f;} row_t;
   row_t        rows [7] = '{'{3'h1, 20'h0, 8'h5a, 5'h00}, '{3'h0, 20'h3, 8'ha5, 5'h01},
                             '{3'h5, 20'h7, 8'h3c, 5'h02}, '{3'h4, 20'h1, 8'hc3, 5'h04},
                             '{3'h1, 20'h2, 8'h0f, 5'h08}, '{3'h5, 20'h0, 8'hf0, 5'h10},
                             '{3'h0, 20'h4, 8'h81, 5'h00}};
   logic        clk = 0, rst = 1, fire = 0, plc_busy, measure_start_n, meas_start;
   logic        measure_done_n, analog_done_n, meas_error_n, analog_end = 0, meas_done = 0;
   logic [7:0]  judge_n, judge_in = 0, prev_n = 8'hff;
   logic [4:0]  fault_in = 0;
   logic [3:0]  reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, rd;
   logic        reg_wr = 0, reg_rd = 0;
   int          num_errors = 0, checks_done = 0, cycles = 0, n, k;

   measure_start_n_judge_port i_measure_start_n_judge_port (.clk(clk), .rst(rst), .measure_start_n(measure_start_n),
      .measure_done_n(measure_done_n), .analog_done_n(analog_done_n), .judge_n(judge_n),
      .meas_error_n(meas_error_n), .meas_start(meas_start), .analog_end(analog_end),
      .meas_done(meas_done), .judge_in(judge_in), .fault_in(fault_in), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   plc_model #(.HOLD_CYC(`MEASURE_START_N_MIN_CYC)) i_plc_model (.clk(clk), .rst(rst), .fire(fire),
      .measure_start_n(measure_start_n), .busy(plc_busy));

   always #20 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles > 80000) begin
         num_errors++;
         close_out();
      end
   end

   task automatic close_out();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic reg_io(logic w, logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge clk);
      rd = reg_rdata;
   endtask
   task automatic pulse_fire();
      @(posedge clk);
      while (plc_busy) @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
   endtask
   // Waits at most lim cycles for a start pulse, stopping at the first one seen; n counts it
   task automatic wait_start(int lim);
      n = 0;
      k = 0;
      while (k < lim && !(n > 0 && lim > 10000)) begin
         @(negedge clk);
         k++;
         if (meas_start === 1'b1) n++;
         if (n > 0 && lim < 10000) break;
      end
   endtask
   task automatic finish(logic [7:0] j, logic [4:0] f);
      @(posedge clk);
      analog_end <= 1'b1;
      @(posedge clk);
      analog_end <= 1'b0;
      meas_done <= 1'b1;
      judge_in <= j;
      fault_in <= f;
      @(posedge clk);
      meas_done <= 1'b0;
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK({measure_done_n, analog_done_n, meas_error_n, judge_n}, 11'h7ff)
      reg_io(1'b0, `OFF_CTRL, 0);
      `CHK(rd, 32'h1)
      reg_io(1'b1, 4'hf, 32'hffff);
      reg_io(1'b0, 4'hf, 0);
      `CHK(rd, 32'h0)
      foreach (rows[i]) begin
         // Edge mode may only change once the pin is back at rest, else a stale edge fires
         while (plc_busy) @(posedge clk);
         @(negedge clk);
         if (i > 0) `CHK({measure_done_n, analog_done_n}, 2'b00)
         reg_io(1'b1, `OFF_CTRL, {29'h0, rows[i].c});
         reg_io(1'b1, `OFF_DELAY, {12'h0, rows[i].d});
         pulse_fire();
         wait_start(6000);
         `CHK(n, 1)
         `CHK(measure_start_n, rows[i].c[2])
         @(negedge clk);
         `CHK({measure_done_n, analog_done_n}, 2'b11)
         `CHK(judge_n, rows[i].c[0] ? 8'hff : prev_n)
         finish(rows[i].j, rows[i].f);
         @(negedge clk);
         // Done strobes stay released until the delay of the very first measurement after reset runs out
         `CHK({judge_n, meas_error_n, analog_done_n}, {~rows[i].j, rows[i].f == 0, i == 0})
         prev_n = ~rows[i].j;
         for (k = 1; k < 100 && measure_done_n !== 1'b0; k++) @(negedge clk);
         `CHK(k, rows[i].d + 2)
         reg_io(1'b0, `OFF_RESULT, 0);
         `CHK(rd[7:0], rows[i].j)
         reg_io(1'b0, `OFF_STATUS, 0);
         `CHK(rd[4:0], {rows[i].f != 0, 4'h0})
      end
      // Second trigger inside a running measurement, first ignored then taken
      for (int m = 1; m <= 3; m += 2) begin
         reg_io(1'b1, `OFF_CTRL, m);
         pulse_fire();
         wait_start(6000);
         pulse_fire();
         wait_start(m == 1 ? 12000 : 6000);
         `CHK(n, m == 1 ? 0 : 1)
         finish(8'h11, 5'h00);
      end
      rst <= 1'b1;
      @(negedge clk);
      `CHK({measure_done_n, judge_n}, 9'h1ff)
      close_out();
   end
endmodule
